/* dsm_pkg.sv */
// constants shared by the modulator source and carrier select block
package dsm_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] MOD_SRC_OFS = 8'h00;
  localparam logic [7:0] HC_SEL_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // field positions and write masks
  // ----------------------------------------------------------------
  localparam int PIN_DIS_BIT = 7;
  localparam int HC_INV_BIT = 6;
  localparam int HC_SYNC_BIT = 5;
  localparam int ENABLE_BIT = 7;
  localparam int OUT_STAT_BIT = 3;
  localparam int SW_BIT_POS = 0;
  localparam logic [7:0] MOD_SRC_WMASK = 8'h8F;
  localparam logic [7:0] HC_SEL_WMASK = 8'hEF;

  // ----------------------------------------------------------------
  // selector codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MOD_SW_CODE = 4'h0;
  localparam logic [3:0] MOD_PWM_BASE = 4'h2;
  localparam logic [3:0] MOD_CMP_BASE = 4'h6;
  localparam logic [3:0] MOD_SPI_BASE = 4'h8;
  localparam logic [3:0] MOD_UART_CODE = 4'hA;
  localparam logic [3:0] HC_GND_CODE = 4'h0;
  localparam logic [3:0] HC_REF_CODE = 4'h3;
  localparam logic [3:0] HC_PWM_BASE = 4'h4;

  // ----------------------------------------------------------------
  // values after power-on reset (documented as unknown)
  // ----------------------------------------------------------------
  localparam logic [7:0] MOD_SRC_RST = 8'h00;
  localparam logic [7:0] HC_SEL_RST = 8'h00;

endpackage : dsm_pkg

/* sel_mux.sv */
// one-of-n signal selector, output is the src bit indexed by sel, with no default for unused codes
`timescale 1ns/10ps
module sel_mux #(
  parameter int N = 16,
  parameter int SEL_W = 4
) (
  // ---- sources
  input wire logic [N-1:0] src,
  // ---- select and result
  input wire logic [SEL_W-1:0] sel,
  output logic y
);
  import dsm_pkg::*;

  always_comb begin
    y = src[sel];
  end

endmodule : sel_mux

/* carrier_switch.sv */
// decides when the mixer leaves the high carrier for the low one
`timescale 1ns/10ps
module carrier_switch (
  // ---- clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // ---- signals
  input wire logic mod_sig,
  input wire logic hc_sig,
  input wire logic sync_en,
  output logic use_high
);
  import dsm_pkg::*;

  typedef struct packed {
    logic hc_prev;
    logic use_high;
  } sw_state_t;

  sw_state_t st_r;
  sw_state_t st_nxt;
  logic hc_fall;

  assign hc_fall = st_r.hc_prev & ~hc_sig;
  assign use_high = st_r.use_high;

  always_comb begin
    st_nxt = st_r;
    st_nxt.hc_prev = hc_sig;
    if (mod_sig) begin
      st_nxt.use_high = 1'b1;
    end else if (!sync_en) begin
      st_nxt.use_high = 1'b0;
    end else if (hc_fall) begin
      st_nxt.use_high = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hold_until_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r.use_high && !mod_sig && sync_en && !hc_fall) |=> st_r.use_high)
    else $error("high carrier left before its falling edge");
  switch_now_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!mod_sig && !sync_en) |=> !st_r.use_high)
    else $error("unsynced switch to low carrier was late");
  sync_switch_c: cover property (@(posedge clk) disable iff (!arst_n)
    (st_r.use_high && !mod_sig && sync_en) ##1 !st_r.use_high);

endmodule : carrier_switch

/* dsm_select.sv */
// modulator source and high carrier selection with its register slave
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - codes 0 to 10 pick modulator source
// - codes 11 to 15 give no source
// - source pin disable suppresses peripheral pin drive
// - unused bits read zero, ignore writes
// - high carrier codes 0 to 7 select
// - carrier pin disable suppresses peripheral pin drive
// - polarity bit inverts selected high carrier
// - sync waits for high carrier falling edge
// - without sync, switch away at once
// - selections undefined at power-on, kept otherwise; here power-on reset clears both to zero
// - mixing only while module enable set
// - software bit drives modulator when selected
module dsm_select (
  // ---- clock and resets
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sys_rst_n,
  // ---- axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [dsm_pkg::ADDR_W-1:0] awaddr,
  // ---- axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [dsm_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // ---- axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // ---- axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [dsm_pkg::ADDR_W-1:0] araddr,
  // ---- axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [dsm_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // ---- peripheral and pin sources
  input wire logic [3:0] pwm_in,
  input wire logic [1:0] cmp_in,
  input wire logic [1:0] spi_sdo_in,
  input wire logic uart_tx_in,
  input wire logic ref_clk_in,
  input wire logic mod_input_pin,
  input wire logic carrier_input_pin_one,
  input wire logic carrier_input_pin_two,
  input wire logic low_carrier_in,
  // ---- peripheral pin drive suppression
  output logic [3:0] pwm_pin_off,
  output logic [1:0] cmp_pin_off,
  output logic [1:0] spi_pin_off,
  output logic uart_pin_off,
  output logic ref_clk_pin_off,
  // ---- mixer result
  output logic mixed_out,
  output logic high_carrier_active
);
  import dsm_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane0;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [7:0] mod_src;
    logic [7:0] hc_sel;
    logic enable;
    logic sw_bit;
    logic mixed;
    logic hc_active;
    logic [3:0] pwm_off;
    logic [1:0] cmp_off;
    logic [1:0] spi_off;
    logic uart_off;
    logic ref_off;
  } dsm_state_t;

  dsm_state_t st_r;
  dsm_state_t st_nxt;

  logic [15:0] mod_src_vec;
  logic [15:0] hc_src_vec;
  logic mod_sig;
  logic hc_raw;
  logic hc_sig;
  logic use_high;
  logic [3:0] mod_code;
  logic [3:0] hc_code;
  logic mod_dis;
  logic hc_dis;

  assign mod_code = st_r.mod_src[3:0];
  assign hc_code = st_r.hc_sel[3:0];
  assign mod_dis = st_r.mod_src[PIN_DIS_BIT];
  assign hc_dis = st_r.hc_sel[PIN_DIS_BIT];

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // upper codes feed constant zero: no channel, no source
  assign mod_src_vec = {5'h00, uart_tx_in, spi_sdo_in, cmp_in, pwm_in, mod_input_pin, st_r.sw_bit};
  assign hc_src_vec = {8'h00, pwm_in, ref_clk_in, carrier_input_pin_two, carrier_input_pin_one, 1'b0};

  sel_mux #(.N(16), .SEL_W(4)) u_mod_mux (
    .src(mod_src_vec),
    .sel(mod_code),
    .y(mod_sig)
  );

  sel_mux #(.N(16), .SEL_W(4)) u_hc_mux (
    .src(hc_src_vec),
    .sel(hc_code),
    .y(hc_raw)
  );

  assign hc_sig = hc_raw ^ st_r.hc_sel[HC_INV_BIT];

  carrier_switch u_switch (
    .clk(clk),
    .arst_n(arst_n),
    .mod_sig(mod_sig),
    .hc_sig(hc_sig),
    .sync_en(st_r.hc_sel[HC_SYNC_BIT]),
    .use_high(use_high)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // write channels are taken independently, in either order
    if (awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = wdata[7:0];
      st_nxt.w_lane0 = wstrb[0];
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if (st_r.aw_addr == MOD_SRC_OFS) begin
        if (st_r.w_lane0) begin
          st_nxt.mod_src = st_r.w_data & MOD_SRC_WMASK;
        end
      end else if (st_r.aw_addr == HC_SEL_OFS) begin
        if (st_r.w_lane0) begin
          st_nxt.hc_sel = st_r.w_data & HC_SEL_WMASK;
        end
      end else if (st_r.aw_addr == CTRL_OFS) begin
        if (st_r.w_lane0) begin
          st_nxt.enable = st_r.w_data[ENABLE_BIT];
          st_nxt.sw_bit = st_r.w_data[SW_BIT_POS];
        end
      end else begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end
    st_nxt.awready = !st_nxt.aw_have;
    st_nxt.wready = !st_nxt.w_have;
    // read path: one read at a time, data straight from the registers
    // unused bits are masked again here, so they read zero whatever was stored
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.rdata = '0;
      if (araddr == MOD_SRC_OFS) begin
        st_nxt.rdata[7:0] = st_r.mod_src & MOD_SRC_WMASK;
      end else if (araddr == HC_SEL_OFS) begin
        st_nxt.rdata[7:0] = st_r.hc_sel & HC_SEL_WMASK;
      end else if (araddr == CTRL_OFS) begin
        st_nxt.rdata[ENABLE_BIT] = st_r.enable;
        st_nxt.rdata[OUT_STAT_BIT] = st_r.mixed;
        st_nxt.rdata[SW_BIT_POS] = st_r.sw_bit;
      end else begin
        st_nxt.rresp = RESP_SLVERR;
      end
    end
    st_nxt.arready = !st_nxt.rvalid;
    // peripheral pin drive suppression follows the current selection
    for (int i = 0; i < 4; i++) begin
      st_nxt.pwm_off[i] = (mod_dis && mod_code == MOD_PWM_BASE + 4'(i))
                        || (hc_dis && hc_code == HC_PWM_BASE + 4'(i));
    end
    for (int i = 0; i < 2; i++) begin
      st_nxt.cmp_off[i] = mod_dis && mod_code == MOD_CMP_BASE + 4'(i);
      st_nxt.spi_off[i] = mod_dis && mod_code == MOD_SPI_BASE + 4'(i);
    end
    st_nxt.uart_off = mod_dis && mod_code == MOD_UART_CODE;
    st_nxt.ref_off = hc_dis && hc_code == HC_REF_CODE;
    // mixer: output held low while the module is off
    st_nxt.hc_active = use_high;
    if (st_r.enable) begin
      st_nxt.mixed = use_high ? hc_sig : low_carrier_in;
    end else begin
      st_nxt.mixed = 1'b0;
    end
    // other device resets clear control but keep the selections
    if (!sys_rst_n) begin
      st_nxt.enable = 1'b0;
      st_nxt.sw_bit = 1'b0;
      st_nxt.mixed = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
      st_r.mod_src <= MOD_SRC_RST;
      st_r.hc_sel <= HC_SEL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign pwm_pin_off = st_r.pwm_off;
  assign cmp_pin_off = st_r.cmp_off;
  assign spi_pin_off = st_r.spi_off;
  assign uart_pin_off = st_r.uart_off;
  assign ref_clk_pin_off = st_r.ref_off;
  assign mixed_out = st_r.mixed;
  assign high_carrier_active = st_r.hc_active;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // which selection register the pending read came from, for the unused-bit checks
  logic rd_mod_r;
  logic rd_hc_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_mod_r <= 1'b0;
      rd_hc_r <= 1'b0;
    end else if (arvalid && st_r.arready) begin
      rd_mod_r <= (araddr == MOD_SRC_OFS);
      rd_hc_r <= (araddr == HC_SEL_OFS);
    end
  end

  mod_route_a: assert property (
    (mod_code == MOD_UART_CODE) |-> (mod_sig == uart_tx_in))
    else $error("uart code did not route uart transmit");
  mod_none_a: assert property (
    (mod_code > MOD_UART_CODE) |-> !mod_sig)
    else $error("reserved modulator code routed a signal");
  sw_bit_a: assert property (
    (mod_code == MOD_SW_CODE) |-> (mod_sig == st_r.sw_bit))
    else $error("software bit not used as modulator");
  mod_pin_off_a: assert property (
    (mod_dis && mod_code == MOD_UART_CODE) |=> uart_pin_off)
    else $error("uart pin drive not suppressed");
  hc_pin_off_a: assert property (
    (hc_dis && hc_code == HC_REF_CODE) |=> ref_clk_pin_off)
    else $error("reference clock pin drive not suppressed");
  unused_mod_a: assert property (
    (st_r.rvalid && rd_mod_r) |-> (st_r.rdata[6:4] == 3'h0))
    else $error("unimplemented source select bit read back nonzero");
  unused_hc_a: assert property (
    (st_r.rvalid && rd_hc_r) |-> (st_r.rdata[4] == 1'b0))
    else $error("unimplemented carrier select bit read back nonzero");
  hc_gnd_a: assert property (
    (hc_code == HC_GND_CODE || hc_code > HC_PWM_BASE + 4'h3) |-> !hc_raw)
    else $error("ground or reserved carrier code not low");
  hc_invert_a: assert property (
    st_r.hc_sel[HC_INV_BIT] |-> (hc_sig == !hc_raw))
    else $error("high carrier not inverted");
  sel_keep_a: assert property (
    (!sys_rst_n && !(st_r.aw_have && st_r.w_have && !st_r.bvalid)) |=> $stable(st_r.mod_src))
    else $error("selection changed by device reset");
  disabled_low_a: assert property (
    !st_r.enable |=> !mixed_out)
    else $error("output active while disabled");
  mix_follow_a: assert property (
    (st_r.enable && sys_rst_n && use_high) |=> (mixed_out == $past(hc_sig)))
    else $error("output did not follow high carrier");
  mix_low_a: assert property (
    (st_r.enable && sys_rst_n && !use_high) |=> (mixed_out == $past(low_carrier_in)))
    else $error("output did not follow low carrier");
  pwm_mod_off_a: assert property (
    (mod_dis && mod_code == MOD_PWM_BASE) |=> pwm_pin_off[0])
    else $error("first pwm pin drive not suppressed by source select");
  hc_pwm_off_a: assert property (
    (hc_dis && hc_code == HC_PWM_BASE + 4'h3) |=> pwm_pin_off[3])
    else $error("last pwm pin drive not suppressed by carrier select");
  pin_drive_on_a: assert property (
    (!mod_dis && !hc_dis) |=> ({pwm_pin_off, cmp_pin_off, spi_pin_off, uart_pin_off, ref_clk_pin_off} == 10'h000))
    else $error("pin drive suppressed while both disables clear");
  hc_pass_a: assert property (
    !st_r.hc_sel[HC_INV_BIT] |-> (hc_sig == hc_raw))
    else $error("high carrier altered while polarity bit clear");
  hc_keep_a: assert property (
    (!sys_rst_n && !(st_r.aw_have && st_r.w_have && !st_r.bvalid)) |=> $stable(st_r.hc_sel))
    else $error("carrier selection changed by device reset");

  write_c: cover property (st_r.bvalid && bready && st_r.bresp == RESP_OKAY);
  read_c: cover property (st_r.rvalid && rready);
  mix_c: cover property (st_r.enable && use_high ##1 mixed_out);
  low_c: cover property (st_r.enable && !use_high && low_carrier_in ##1 mixed_out);

endmodule : dsm_select

/* src_model.sv */
// stand-in for the on-chip peripherals and modulation pins feeding the selector
`timescale 1ns/10ps
module src_model (
  // ---- clock
  input wire logic clk,
  // ---- requested levels
  input wire logic [13:0] pat,
  // ---- source outputs
  output logic [3:0] pwm_o,
  output logic [1:0] cmp_o,
  output logic [1:0] sdo_o,
  output logic tx_o,
  output logic ref_o,
  output logic min_o,
  output logic cin1_o,
  output logic cin2_o,
  output logic lc_o
);
  // ----------------------------------------------------------------
  // registered source levels
  // ----------------------------------------------------------------
  logic [13:0] q = '0;
  // pwm units are taken to run in pwm output mode, so their level is a valid source
  always @(posedge clk) begin
    q <= pat;
  end
  assign {lc_o, cin2_o, cin1_o, min_o, ref_o, tx_o, sdo_o, cmp_o, pwm_o} = q;
endmodule : src_model

/* test_dsm_select.sv */
// self-checking bench for the modulator source and high carrier selection
`timescale 1ns/10ps
module test_dsm_select;
  import dsm_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ms;
    logic [7:0] hs;
    logic [7:0] ct;
    logic [13:0] pat;
    logic mix;
    logic [9:0] off;
  } row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sys_rst_n = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, mixed_out, high_carrier_active;
  logic [1:0] bresp, rresp, rsp;
  logic [DATA_W-1:0] rdata, rd;
  logic [3:0] pwm_in, pwm_pin_off;
  logic [1:0] cmp_in, spi_sdo_in, cmp_pin_off, spi_pin_off;
  logic uart_tx_in, ref_clk_in, min, cin1, cin2, lc, uart_pin_off, ref_clk_pin_off;
  logic [13:0] pat = '0;
  logic [9:0] off;
  row_t rows [32];
  int fails = 0;
  int check_count = 0;
  assign off = {ref_clk_pin_off, uart_pin_off, spi_pin_off, cmp_pin_off, pwm_pin_off};
  always #5 clk = ~clk;
  // ----------------------------------------------------------------
  // design and source model
  // ----------------------------------------------------------------
  dsm_select dut (.clk(clk), .arst_n(arst_n), .sys_rst_n(sys_rst_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .pwm_in(pwm_in), .cmp_in(cmp_in), .spi_sdo_in(spi_sdo_in),
    .uart_tx_in(uart_tx_in), .ref_clk_in(ref_clk_in), .mod_input_pin(min), .carrier_input_pin_one(cin1),
    .carrier_input_pin_two(cin2), .low_carrier_in(lc), .pwm_pin_off(pwm_pin_off), .cmp_pin_off(cmp_pin_off),
    .spi_pin_off(spi_pin_off), .uart_pin_off(uart_pin_off), .ref_clk_pin_off(ref_clk_pin_off),
    .mixed_out(mixed_out), .high_carrier_active(high_carrier_active));
  src_model peri (.clk(clk), .pat(pat), .pwm_o(pwm_in), .cmp_o(cmp_in), .sdo_o(spi_sdo_in), .tx_o(uart_tx_in),
    .ref_o(ref_clk_in), .min_o(min), .cin1_o(cin1), .cin2_o(cin2), .lc_o(lc));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : chk
  // address and data are offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rdreg(input logic [7:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rdreg
  task automatic setup(input logic [13:0] p, input logic [7:0] ms, input logic [7:0] hs, input logic [7:0] ct);
    @(posedge clk);
    pat <= p;
    wr(MOD_SRC_OFS, ms);
    wr(HC_SEL_OFS, hs);
    wr(CTRL_OFS, ct);
    repeat (4) @(posedge clk);
  endtask : setup
  // rows 0-15 walk the modulator codes, 16-31 the high carrier codes
  function automatic row_t mk(input int i);
    row_t r;
    int c;
    c = i % 16;
    r = '0;
    if (i < 16) begin
      r.ms = {4'h8, c[3:0]};
      r.hs = 8'h40;
      r.ct = (c == 0 || c > 10) ? 8'h81 : 8'h80;
      r.mix = (c <= 10);
      r.pat = (c == 1) ? 14'h0400 : (c > 10) ? 14'h1FFF : (c >= 2) ? 14'h1 << (c - 2) : 14'h0;
      r.off = (c >= 2 && c <= 10) ? 10'h1 << (c - 2) : 10'h0;
    end else begin
      r.hs = {4'h8, c[3:0]};
      r.ct = 8'h81;
      r.mix = (c >= 1 && c <= 7);
      r.pat = (c == 1) ? 14'h0800 : (c == 2) ? 14'h1000 : (c == 3) ? 14'h0200 :
        (c >= 4 && c <= 7) ? 14'h1 << (c - 4) : 14'h1FFF;
      r.off = (c == 3) ? 10'h200 : (c >= 4 && c <= 7) ? 10'h1 << (c - 4) : 10'h0;
    end
    return r;
  endfunction : mk
  // ----------------------------------------------------------------
  // watchdog, sized well above the expected run
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 32; i++) rows[i] = mk(i);
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdreg(MOD_SRC_OFS);
    chk(rd, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rdreg(CTRL_OFS);
    chk(rd, 32'h0);
    for (int i = 0; i < 32; i++) begin
      setup(rows[i].pat, rows[i].ms, rows[i].hs, rows[i].ct);
      chk({31'h0, mixed_out}, {31'h0, rows[i].mix});
      chk({22'h0, off}, {22'h0, rows[i].off});
      rdreg(i < 16 ? MOD_SRC_OFS : HC_SEL_OFS);
      chk(rd, {24'h0, i < 16 ? rows[i].ms : rows[i].hs});
      rdreg(CTRL_OFS);
      chk(rd, {24'h0, rows[i].ct | {4'h0, rows[i].mix, 3'h0}});
    end
    wr(MOD_SRC_OFS, 8'hFF);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rdreg(MOD_SRC_OFS);
    chk(rd, 32'h8F);
    wr(HC_SEL_OFS, 8'hFF);
    rdreg(HC_SEL_OFS);
    chk(rd, 32'hEF);
    // unmapped place: refused with an error, reads zero
    wr(8'h0C, 8'h55);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    rdreg(8'h0C);
    chk(rd, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    setup(14'h0, 8'h00, 8'h41, 8'h81);
    chk({31'h0, mixed_out}, 32'h1);
    setup(14'h0, 8'h00, 8'h40, 8'h01);
    chk({31'h0, mixed_out}, 32'h0);
    // carrier held high while the modulator drops: sync keeps the high carrier
    setup(14'h0800, 8'h00, 8'h21, 8'h81);
    chk({31'h0, high_carrier_active}, 32'h1);
    wr(CTRL_OFS, 8'h80);
    repeat (4) @(posedge clk);
    chk({31'h0, high_carrier_active}, 32'h1);
    pat <= 14'h0;
    repeat (4) @(posedge clk);
    chk({31'h0, high_carrier_active}, 32'h0);
    // carrier stays high with no falling edge: without sync the switch must not wait
    setup(14'h0800, 8'h80, 8'h01, 8'h81);
    chk({31'h0, high_carrier_active}, 32'h1);
    wr(CTRL_OFS, 8'h80);
    repeat (3) @(posedge clk);
    chk({31'h0, high_carrier_active}, 32'h0);
    sys_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    sys_rst_n <= 1'b1;
    rdreg(MOD_SRC_OFS);
    chk(rd, 32'h80);
    rdreg(HC_SEL_OFS);
    chk(rd, 32'h01);
    rdreg(CTRL_OFS);
    chk(rd, 32'h0);
    // power-on reset in mid-run clears the outputs and the selections
    setup(14'h0001, 8'h82, 8'h84, 8'h80);
    chk({31'h0, mixed_out}, 32'h1);
    chk({22'h0, off}, 32'h1);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({20'h0, off, mixed_out, high_carrier_active}, 32'h0);
    arst_n <= 1'b1;
    rdreg(HC_SEL_OFS);
    chk(rd, {24'h0, HC_SEL_RST});
    report_and_stop();
  end
endmodule : test_dsm_select
